// [shared/lcf_pkg.sv]
// constants and types for the laser channel fault and configuration block
package lcf_pkg;

  // register port widths
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [5:0] OFF_STAT0    = 6'h00;
  localparam logic [5:0] OFF_STAT1    = 6'h01;
  localparam logic [5:0] OFF_CH1_MODE = 6'h10;
  localparam logic [5:0] OFF_CH1_REG  = 6'h13;
  localparam logic [5:0] OFF_CH2_MODE = 6'h15;
  localparam logic [5:0] OFF_CH2_REG  = 6'h18;
  localparam logic [5:0] OFF_DISABLE  = 6'h19;
  localparam logic [5:0] OFF_MERGE    = 6'h1B;
  localparam logic [5:0] OFF_MASK     = 6'h1D;

  // field positions inside the channel mode byte
  localparam int unsigned B_XCAP = 1;
  localparam int unsigned B_OFFC = 4;
  // field positions inside the channel regulator byte
  localparam int unsigned B_SPEED = 4;
  localparam int unsigned B_SAT   = 2;
  // field positions in the combine, disable and mask bytes
  localparam int unsigned B_MERGE  = 6;
  localparam int unsigned B_DIS1   = 0;
  localparam int unsigned B_DIS2   = 1;
  localparam int unsigned B_M_OSC  = 0;
  localparam int unsigned B_M_SAT1 = 2;
  localparam int unsigned B_M_SAT2 = 3;

  // primary status bit positions
  localparam int unsigned S0_MEMRDY = 0;
  localparam int unsigned S0_MAINDN = 1;
  localparam int unsigned S0_MEMCHK = 2;
  localparam int unsigned S0_HOT    = 3;
  localparam int unsigned S0_OC2    = 4;
  localparam int unsigned S0_OC1    = 5;
  localparam int unsigned S0_OSC    = 6;
  localparam int unsigned S0_TIMO   = 7;
  // secondary status bit positions, channel 2 sits one nibble higher
  localparam int unsigned S1_STATE  = 0;
  localparam int unsigned S1_MON    = 1;
  localparam int unsigned S1_SAT    = 2;
  localparam int unsigned S1_SUPDN  = 3;
  localparam int unsigned S1_CH2    = 4;

  // reset values
  localparam logic [2:0] RST_SPEED = 3'h3;
  localparam logic [1:0] RST_SAT   = 2'h0;
  localparam logic       RST_XCAP  = 1'h0;
  localparam logic       RST_OFFC  = 1'h1;
  localparam logic       RST_MERGE = 1'h0;
  localparam logic       RST_M_OSC = 1'h0;
  localparam logic       RST_M_SAT = 1'h1;
  localparam logic       RST_DISC  = 1'h1;
  localparam logic [7:0] RST_STAT0 = 8'h03;
  localparam logic [7:0] RST_STAT1 = 8'h88;
  // secondary status bits that count as errors
  localparam logic [7:0] ERR1_MASK = 8'hCC;

  // regulator settings of one channel
  typedef struct packed {
    logic [2:0] loop_speed_field;
    logic [1:0] sat_threshold_sel;
    logic       ext_cap_select_bit;
    logic       offset_cancel_enable;
  } lcf_ch_cfg_t;

  // condition inputs from comparators, monitors and pins
  typedef struct packed {
    logic memory_check_error;
    logic overtemp;
    logic ch1_overcurrent;
    logic ch2_overcurrent;
    logic osc_monitor_fail;
    logic setup_timeout;
    logic standby_exit;
    logic ch1_saturated;
    logic ch2_saturated;
    logic laser_supply_1_down;
    logic laser_supply_2_down;
    logic laser_supply_mismatch;
    logic ch1_monitor_on;
    logic ch2_monitor_on;
    logic select_pin_open;
    logic aux_pin_open;
    logic laser_enable_pin_1;
    logic laser_enable_pin_2;
  } lcf_cond_t;

endpackage

// [logic/lcf_sync.sv]
// two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module lcf_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  // levels in and out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;       // first stage, read only by the second
  logic [W-1:0] next_meta;  // next first stage
  logic [W-1:0] next_q;     // next second stage

  // next stage values
  always_comb begin
    next_meta = d_i;
    next_q    = meta;
  end

  // both stages clear on reset
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end

endmodule
`default_nettype wire

// [logic/lcf_core.sv]
// laser channel configuration registers, fault flags and enable logic
`timescale 1ns/100ps
`default_nettype none
// How it works
// - 3-bit loop speed per channel, reset 011
// - offset cancellation bit per channel, reset one
// - oscillator failure disables lasers, flags, alerts
// - oscillator mask bit 0x1D.0 hides alert
// - 2-bit saturation threshold select, reset 00
// - saturation sets secondary flag and alerts
// - saturation masks 0x1D bits 2,3 reset one
// - open select or aux pin blocks lasers
// - disable bit set keeps channel off
// - any error disables; unmasked changes alert
// - primary status layout at 0x00
// - secondary status layout at 0x01
// - status read acknowledges pending errors
// - power-on sets supply and memory flags
// - standby exit sets main supply flag
// - overcurrent, temperature, memory, timeout disable lasers
// - combine bit parallels channel 2 under 1
// - combined supply mismatch sets supply flag 1
// - combined: flag 2 on either supply down
module lcf_core
  import lcf_pkg::*;
(
  // clock and reset
  input  wire logic                          mclk_i,
  input  wire logic                          rst_n_i,
  // register access port from the serial front end
  input  wire logic [lcf_pkg::ADDR_W-1:0]    reg_addr_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  input  wire logic [lcf_pkg::DATA_W-1:0]    reg_wdata_i,
  output logic      [lcf_pkg::DATA_W-1:0]    reg_rdata_o,
  // conditions from comparators, monitors and pins
  input  wire lcf_pkg::lcf_cond_t            cond_i,
  // regulator settings out to the analog channels
  output lcf_pkg::lcf_ch_cfg_t               ch1_cfg_o,
  output lcf_pkg::lcf_ch_cfg_t               ch2_cfg_o,
  // laser channel control
  output logic      [1:0]                    laser_en_o,
  output logic                               ch2_parallel_o,
  // fault alert, active low
  output logic                               fault_alert_output_n_o
);

  import lcf_pkg::*;

  // synchronised condition inputs
  lcf_cond_t   cond;
  // delayed standby exit level for edge detection
  logic        standby_d;
  logic        next_standby_d;
  logic        standby_pulse;

  // configuration registers
  lcf_ch_cfg_t ch1_cfg;
  lcf_ch_cfg_t ch2_cfg;
  lcf_ch_cfg_t next_ch1_cfg;
  lcf_ch_cfg_t next_ch2_cfg;
  logic        channel_combine;
  logic        next_channel_combine;
  logic        osc_fault_mask;
  logic        next_osc_fault_mask;
  logic [1:0]  sat_flag_mask;
  logic [1:0]  next_sat_flag_mask;
  logic [1:0]  disable_bit;
  logic [1:0]  next_disable_bit;

  // status registers
  logic [7:0]  stat0;
  logic [7:0]  stat1;
  logic [7:0]  next_stat0;
  logic [7:0]  next_stat1;
  logic [7:0]  cause0;
  logic [7:0]  cause1;

  // channel state and alert
  logic [1:0]  ch_on;
  logic [1:0]  next_ch_on;
  logic        next_alert_n;
  logic [7:0]  next_rdata;

  // access decode
  logic        ack0;
  logic        ack1;
  logic        any_err;
  logic        pins_open;

  // byte image of a channel mode register
  function automatic logic [7:0] mode_byte(input lcf_ch_cfg_t c);
    logic [7:0] b;
    b         = 8'h00;
    b[B_XCAP] = c.ext_cap_select_bit;
    b[B_OFFC] = c.offset_cancel_enable;
    return b;
  endfunction

  // byte image of a channel regulator register
  function automatic logic [7:0] reg_byte(input lcf_ch_cfg_t c);
    logic [7:0] b;
    b                 = 8'h00;
    b[B_SPEED +: 3]   = c.loop_speed_field;
    b[B_SAT +: 2]     = c.sat_threshold_sel;
    return b;
  endfunction

  // sticky flag update: a present cause always wins over the clear
  function automatic logic [7:0] sticky_next(
    input logic [7:0] cur,
    input logic [7:0] cause,
    input logic       ack
  );
    return cause | (cur & ~{8{ack}});
  endfunction

  // all pin and comparator levels come from outside this clock
  lcf_sync #(
    .W ($bits(lcf_cond_t))
  ) u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     (cond_i),
    .q_o     (cond)
  );

  // standby exit edge from the synchronised level
  always_comb begin
    next_standby_d = cond.standby_exit;
    standby_pulse  = cond.standby_exit & ~standby_d;
  end

  // edge detector register
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      standby_d <= 1'b0;
    end else begin
      standby_d <= next_standby_d;
    end
  end

  // reading a status register acknowledges it
  always_comb begin
    ack0 = reg_rd_i && (reg_addr_i == OFF_STAT0);
    ack1 = reg_rd_i && (reg_addr_i == OFF_STAT1);
  end

  // configuration register writes
  always_comb begin
    next_ch1_cfg         = ch1_cfg;
    next_ch2_cfg         = ch2_cfg;
    next_channel_combine = channel_combine;
    next_osc_fault_mask  = osc_fault_mask;
    next_sat_flag_mask   = sat_flag_mask;
    next_disable_bit     = disable_bit;
    if (reg_wr_i) begin
      case (reg_addr_i)
        // offset cancellation and external capacitor bits
        OFF_CH1_MODE: begin
          next_ch1_cfg.ext_cap_select_bit   = reg_wdata_i[B_XCAP];
          next_ch1_cfg.offset_cancel_enable = reg_wdata_i[B_OFFC];
        end
        OFF_CH2_MODE: begin
          next_ch2_cfg.ext_cap_select_bit   = reg_wdata_i[B_XCAP];
          next_ch2_cfg.offset_cancel_enable = reg_wdata_i[B_OFFC];
        end
        OFF_CH1_REG: begin
          next_ch1_cfg.loop_speed_field  = reg_wdata_i[B_SPEED +: 3];
          next_ch1_cfg.sat_threshold_sel = reg_wdata_i[B_SAT +: 2];
        end
        OFF_CH2_REG: begin
          next_ch2_cfg.loop_speed_field  = reg_wdata_i[B_SPEED +: 3];
          next_ch2_cfg.sat_threshold_sel = reg_wdata_i[B_SAT +: 2];
        end
        OFF_DISABLE: begin
          next_disable_bit[0] = reg_wdata_i[B_DIS1];
          next_disable_bit[1] = reg_wdata_i[B_DIS2];
        end
        OFF_MERGE: begin
          next_channel_combine = reg_wdata_i[B_MERGE];
        end
        OFF_MASK: begin
          next_osc_fault_mask   = reg_wdata_i[B_M_OSC];
          next_sat_flag_mask[0] = reg_wdata_i[B_M_SAT1];
          next_sat_flag_mask[1] = reg_wdata_i[B_M_SAT2];
        end
        // status and unmapped offsets ignore writes
        default: begin
          next_disable_bit = disable_bit;
        end
      endcase
    end
  end

  // configuration registers take their reset values
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ch1_cfg         <= '{RST_SPEED, RST_SAT, RST_XCAP, RST_OFFC};
      ch2_cfg         <= '{RST_SPEED, RST_SAT, RST_XCAP, RST_OFFC};
      channel_combine <= RST_MERGE;
      osc_fault_mask  <= RST_M_OSC;
      sat_flag_mask   <= {RST_M_SAT, RST_M_SAT};
      disable_bit     <= {RST_DISC, RST_DISC};
    end else begin
      ch1_cfg         <= next_ch1_cfg;
      ch2_cfg         <= next_ch2_cfg;
      channel_combine <= next_channel_combine;
      osc_fault_mask  <= next_osc_fault_mask;
      sat_flag_mask   <= next_sat_flag_mask;
      disable_bit     <= next_disable_bit;
    end
  end

  // causes behind each status bit
  always_comb begin
    cause0            = 8'h00;
    cause1            = 8'h00;
    // standby exit raises main supply power-down
    cause0[S0_MAINDN] = standby_pulse;
    // memory, temperature, overcurrent and timeout events
    cause0[S0_MEMCHK] = cond.memory_check_error;
    cause0[S0_HOT]    = cond.overtemp;
    cause0[S0_OC2]    = cond.ch2_overcurrent;
    cause0[S0_OC1]    = cond.ch1_overcurrent;
    cause0[S0_OSC]    = cond.osc_monitor_fail;
    cause0[S0_TIMO]   = cond.setup_timeout;
    cause1[S1_MON]            = cond.ch1_monitor_on;
    cause1[S1_MON + S1_CH2]   = cond.ch2_monitor_on;
    cause1[S1_SAT]            = cond.ch1_saturated;
    cause1[S1_SAT + S1_CH2]   = cond.ch2_saturated;
    // combined mode also flags a supply mismatch
    cause1[S1_SUPDN] = cond.laser_supply_1_down
                     | (channel_combine & cond.laser_supply_mismatch);
    cause1[S1_SUPDN + S1_CH2] = cond.laser_supply_2_down
                              | (channel_combine
                                 & cond.laser_supply_1_down);
  end

  // status next values
  always_comb begin
    // an acknowledged flag holds while its cause persists
    next_stat0 = sticky_next(stat0, cause0, ack0);
    next_stat1 = sticky_next(stat1, cause1, ack1);
    // state bits follow the channels, not sticky
    next_stat1[S1_STATE]          = ch_on[0];
    next_stat1[S1_STATE + S1_CH2] = ch_on[1];
  end

  // status registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      stat0 <= RST_STAT0;
      stat1 <= RST_STAT1;
    end else begin
      stat0 <= next_stat0;
      stat1 <= next_stat1;
    end
  end

  // enable decision and alert
  always_comb begin
    // open select or aux pin blocks both channels
    pins_open = cond.select_pin_open | cond.aux_pin_open;
    // any unacknowledged error flag blocks both
    any_err   = (|stat0) | (|(stat1 & ERR1_MASK)) | pins_open;
    next_ch_on[0] = ~disable_bit[0] & cond.laser_enable_pin_1 & ~any_err;
    next_ch_on[1] = ~disable_bit[1] & cond.laser_enable_pin_2 & ~any_err;
    // combined: both stages run together under channel 1
    if (channel_combine) begin
      next_ch_on[0] = next_ch_on[0] & next_ch_on[1];
      next_ch_on[1] = next_ch_on[0];
    end
    // unmasked error flags and open pins drive the alert low
    next_alert_n = ~((|(stat0 & ~(8'(osc_fault_mask) << S0_OSC)))
                   | (stat1[S1_SAT] & ~sat_flag_mask[0])
                   | (stat1[S1_SAT + S1_CH2] & ~sat_flag_mask[1])
                   | stat1[S1_SUPDN]
                   | stat1[S1_SUPDN + S1_CH2]
                   | pins_open);
  end

  // channel state and alert registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ch_on                  <= 2'h0;
      fault_alert_output_n_o <= 1'b1;
    end else begin
      ch_on                  <= next_ch_on;
      fault_alert_output_n_o <= next_alert_n;
    end
  end

  // read data multiplexer
  always_comb begin
    next_rdata = reg_rdata_o;
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFF_STAT0:    next_rdata = stat0;
        OFF_STAT1:    next_rdata = stat1;
        OFF_CH1_MODE: next_rdata = mode_byte(ch1_cfg);
        OFF_CH1_REG:  next_rdata = reg_byte(ch1_cfg);
        OFF_CH2_MODE: next_rdata = mode_byte(ch2_cfg);
        OFF_CH2_REG:  next_rdata = reg_byte(ch2_cfg);
        OFF_DISABLE:  next_rdata = 8'(disable_bit);
        OFF_MERGE:    next_rdata = 8'(channel_combine) << B_MERGE;
        OFF_MASK: begin
          next_rdata           = 8'h00;
          next_rdata[B_M_OSC]  = osc_fault_mask;
          next_rdata[B_M_SAT1] = sat_flag_mask[0];
          next_rdata[B_M_SAT2] = sat_flag_mask[1];
        end
        // unmapped offsets read zero
        default:      next_rdata = 8'h00;
      endcase
    end
  end

  // read data register holds until the next read
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  // outputs toward the analog channels
  always_comb begin
    ch1_cfg_o      = ch1_cfg;
    ch2_cfg_o      = ch2_cfg;
    // channel 2 stage in parallel when combined
    ch2_parallel_o = channel_combine;
    laser_en_o     = ch_on;
  end

endmodule
`default_nettype wire

// [test/lcf_core_asserts.sv]
// port checker for the laser channel fault block, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module lcf_core_chk
  import lcf_pkg::*;
(
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  // register port
  input  wire logic [5:0]           reg_addr_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  input  wire logic [7:0]           reg_wdata_i,
  input  wire logic [7:0]           reg_rdata_o,
  // conditions and outputs
  input  wire lcf_pkg::lcf_cond_t   cond_i,
  input  wire lcf_pkg::lcf_ch_cfg_t ch1_cfg_o,
  input  wire lcf_pkg::lcf_ch_cfg_t ch2_cfg_o,
  input  wire logic [1:0]           laser_en_o,
  input  wire logic                 ch2_parallel_o,
  input  wire logic                 fault_alert_output_n_o
);
  // one clock domain, reset cancels every attempt
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  ch1_reg_a: assert property (
    reg_wr_i && reg_addr_i == 6'h13
    |=> ch1_cfg_o[6:2] == $past(reg_wdata_i[6:2]))
    else $error("ch1 speed or threshold not taken");
  ch2_reg_a: assert property (
    reg_wr_i && reg_addr_i == 6'h18
    |=> ch2_cfg_o[6:2] == $past(reg_wdata_i[6:2]))
    else $error("ch2 speed or threshold not taken");
  offset_bit_a: assert property (
    reg_wr_i && reg_addr_i == 6'h10
    |=> ch1_cfg_o[1:0] == {$past(reg_wdata_i[1]), $past(reg_wdata_i[4])})
    else $error("ch1 mode bits not taken");
  combine_bit_a: assert property (
    reg_wr_i && reg_addr_i == 6'h1B
    |=> ch2_parallel_o == $past(reg_wdata_i[6]))
    else $error("combine output not taken");
  disable_hold_a: assert property (
    reg_wr_i && reg_addr_i == 6'h19 && reg_wdata_i[0] |=> ##1 !laser_en_o[0])
    else $error("ch1 enabled while disabled");
  open_block_a: assert property (
    (cond_i.select_pin_open || cond_i.aux_pin_open) [*4]
    |-> laser_en_o == 2'b00)
    else $error("laser enabled with open pin");
  open_alert_a: assert property (
    cond_i.select_pin_open [*5] |-> !fault_alert_output_n_o)
    else $error("open pin not alerted");
  osc_block_a: assert property (
    cond_i.osc_monitor_fail [*5] |-> laser_en_o == 2'b00)
    else $error("laser enabled with oscillator fault");
  fault_block_a: assert property (
    (cond_i.overtemp || cond_i.ch1_overcurrent || cond_i.setup_timeout) [*5]
    |-> laser_en_o == 2'b00)
    else $error("laser enabled during fault");
  merge_equal_a: assert property (
    ch2_parallel_o && $past(ch2_parallel_o) |-> laser_en_o[0] == laser_en_o[1])
    else $error("combined enables differ");

  // main scenarios reached
  cover property (reg_rd_i && reg_addr_i == 6'h00);
  cover property (!fault_alert_output_n_o ##1 fault_alert_output_n_o);
  cover property (laser_en_o == 2'b11 && ch2_parallel_o);
endmodule
bind lcf_core lcf_core_chk chk (.mclk_i, .rst_n_i, .reg_addr_i, .reg_wr_i,
  .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .cond_i, .ch1_cfg_o, .ch2_cfg_o,
  .laser_en_o, .ch2_parallel_o, .fault_alert_output_n_o);
`default_nettype wire

// [test/lcf_host.sv]
// host controller model driving the register port one byte at a time
`timescale 1ns/100ps
`default_nettype none
module lcf_host (
  // clock and read data
  input  wire logic       mclk_i,
  input  wire logic [7:0] rdata_i,
  // request lines
  output logic      [5:0] addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] wdata_o
);
  // idle bus, no strobe
  initial begin
    addr_o = 6'h3F;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'hFF;
  end
  // single write, then released lines show inverted junk
  task automatic put(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // read acknowledges, data one edge after the taking edge
  task automatic get(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge mclk_i);
    #1;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// [test/lcf_core_bench.sv]
// self-checking bench for the laser channel fault block
`timescale 1ns/100ps
`default_nettype none
module lcf_core_bench;
  import lcf_pkg::*;
  logic        mclk_i = 1'b0;   // 250 MHz clock
  logic        rst_n_i = 1'b0;  // synchronous reset
  logic [5:0]  addr;            // register port
  logic        wr;
  logic        rd;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  lcf_cond_t   cond = '0;       // condition levels
  lcf_ch_cfg_t cfg1;
  lcf_ch_cfg_t cfg2;
  logic [1:0]  en;
  logic        par;
  logic        alert_n;
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;

  always #2 mclk_i = ~mclk_i;

  lcf_core uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .cond_i(cond), .ch1_cfg_o(cfg1), .ch2_cfg_o(cfg2), .laser_en_o(en),
    .ch2_parallel_o(par), .fault_alert_output_n_o(alert_n));
  lcf_host host (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

  // verdict and end of run
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      tally_and_finish;
    end
  end
  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // read and compare; state bits of the secondary byte are ignored
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.get(a, v);
    chk("rdata", v & ((a == 6'h01) ? 8'hEE : 8'hFF), e);
  endtask
  task automatic t_reset;
    logic [5:0] a [8] = '{6'h10, 6'h13, 6'h15, 6'h18,
                          6'h19, 6'h1B, 6'h1D, 6'h3F};
    logic [7:0] e [8] = '{8'h10, 8'h30, 8'h10, 8'h30,
                          8'h03, 8'h00, 8'h0C, 8'h00};
    chk("alert_cfg", {alert_n, cfg1}, 8'h31);
    for (int i = 0; i < 8; i++) begin
      rc(a[i], e[i]);
    end
    rc(6'h00, 8'h03);
    rc(6'h01, 8'h88);
    rc(6'h00, 8'h00);
    rc(6'h01, 8'h00);
  endtask
  task automatic t_cfg;
    for (int i = 0; i < 8; i++) begin
      host.put(6'h13, {1'b0, 3'(i), 2'(i), 2'b00});
      host.put(6'h18, {1'b0, ~3'(i), ~2'(i), 2'b00});
      cy(1);
      chk("cfg1", 8'(cfg1[6:2]), 8'({3'(i), 2'(i)}));
      chk("cfg2", 8'(cfg2[6:2]), 8'({~3'(i), ~2'(i)}));
      rc(6'h18, {1'b0, ~3'(i), ~2'(i), 2'b00});
    end
    // external capacitor with fastest loop speed
    host.put(6'h10, 8'h02);
    host.put(6'h15, 8'h02);
    cy(1);
    chk("cfg1", {1'b0, cfg1}, 8'h7E);
    chk("cfg2", {1'b0, cfg2}, 8'h02);
    host.put(6'h10, 8'h10);
    host.put(6'h15, 8'h10);
    host.put(6'h00, 8'hFF);
    rc(6'h00, 8'h00);
  endtask
  task automatic t_enable;
    for (int i = 3; i >= 0; i--) begin
      host.put(6'h19, 8'(i));
      cy(3);
      chk("en", {6'h00, en}, {6'h00, ~2'(i)});
    end
  endtask
  // monitor-seen bits latch, block nothing and clear on a later read
  task automatic t_monitor;
    logic [7:0] v;
    @(posedge mclk_i);
    cond.ch1_monitor_on <= 1'b1;
    cond.ch2_monitor_on <= 1'b1;
    cy(5);
    host.get(6'h01, v);
    chk("stat1", v, 8'h33);
    chk("en", {6'h00, en}, 8'h03);
    @(posedge mclk_i);
    cond.ch1_monitor_on <= 1'b0;
    cond.ch2_monitor_on <= 1'b0;
    cy(5);
    rc(6'h01, 8'h22);
    rc(6'h01, 8'h00);
  endtask
  // raise one cause, check block, sticky flag, acknowledge and recovery
  task automatic fault(input int b, input logic [5:0] a, input logic [7:0] e,
                       input logic al);
    @(posedge mclk_i) cond[b] <= 1'b1;
    cy(5);
    chk("alert_en", {5'h00, alert_n, en}, {5'h00, al, 2'b00});
    rc(a, e);
    rc(a, e);
    @(posedge mclk_i) cond[b] <= 1'b0;
    cy(5);
    rc(a, e);
    rc(a, 8'h00);
    cy(3);
    chk("alert_en", {5'h00, alert_n, en}, 8'h07);
  endtask
  task automatic t_faults;
    fault(17, 6'h00, 8'h04, 1'b0);
    fault(16, 6'h00, 8'h08, 1'b0);
    fault(15, 6'h00, 8'h20, 1'b0);
    fault(14, 6'h00, 8'h10, 1'b0);
    fault(12, 6'h00, 8'h80, 1'b0);
    fault(13, 6'h00, 8'h40, 1'b0);
    host.put(6'h1D, 8'h0D);
    fault(13, 6'h00, 8'h40, 1'b1);
    host.put(6'h1D, 8'h00);
    fault(10, 6'h01, 8'h04, 1'b0);
    fault(9, 6'h01, 8'h40, 1'b0);
    host.put(6'h1D, 8'h0C);
    fault(10, 6'h01, 8'h04, 1'b1);
    fault(8, 6'h01, 8'h08, 1'b0);
    fault(7, 6'h01, 8'h80, 1'b0);
    fault(3, 6'h00, 8'h00, 1'b0);
    fault(2, 6'h00, 8'h00, 1'b0);
  endtask
  // combine bit, disables clear, both pins high
  // reference halving is a host setting held outside this block
  task automatic t_merge;
    host.put(6'h1B, 8'h40);
    cy(3);
    chk("par_en", {5'h00, par, en}, 8'h07);
    @(posedge mclk_i) cond.laser_enable_pin_2 <= 1'b0;
    cy(5);
    chk("par_en", {5'h00, par, en}, 8'h04);
    @(posedge mclk_i) cond.laser_enable_pin_2 <= 1'b1;
    fault(6, 6'h01, 8'h08, 1'b0);
    fault(8, 6'h01, 8'h88, 1'b0);
    host.put(6'h1B, 8'h00);
    cy(1);
    chk("par", {7'h00, par}, 8'h00);
  endtask
  task automatic t_standby;
    @(posedge mclk_i) cond.standby_exit <= 1'b1;
    cy(5);
    chk("alert_en", {5'h00, alert_n, en}, 8'h00);
    rc(6'h00, 8'h02);
    cy(3);
    chk("alert_en", {5'h00, alert_n, en}, 8'h07);
    @(posedge mclk_i) cond.standby_exit <= 1'b0;
  endtask

  initial begin
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    cond.laser_enable_pin_1 <= 1'b1;
    cond.laser_enable_pin_2 <= 1'b1;
    cy(1);
    t_reset();
    t_cfg();
    t_enable();
    t_monitor();
    t_faults();
    t_merge();
    t_standby();
    tally_and_finish;
  end
endmodule
`default_nettype wire
